// file: hw/bcache_maint_params.svh
// Constants for the backup-cache maintenance block.
// Included by the package and the design module; definitions only.
`ifndef BCACHE_MAINT_PARAMS_SVH
`define BCACHE_MAINT_PARAMS_SVH

`define TS_SEL_HI        24
`define TS_SEL_LO        22
`define TS_SEL_TAGSTORE  3'h4
`define TS_SEL_DEALLOC   3'h5
`define TS_IDX_HI        16
`define TS_IDX_LO        5
`define TS_IDX_W         12
`define TS_DEPTH         4096
`define TS_VALID_BIT     9
`define TS_OWNED_BIT     10
`define TS_ECC_HI        16
`define TS_ECC_LO        11
`define TS_TAG_HI        28
`define TS_TAG_LO        17
`define DEALLOC_RSVD_HI  31
`define DEALLOC_RSVD_LO  25
`define DEALLOC_X_BIT    21
`define DEALLOC_Z_HI     20
`define DEALLOC_Z_LO     17
`define DEALLOC_LOW_HI   4
`define ZERO_WORD        32'h0000_0000
`define ZERO_ECC         6'h00
`define ZERO_TAG         12'h000
`define ZERO_IDX         12'h000

`endif

// file: hw/bcache_maint_pkg.sv
// Types for the backup-cache maintenance block.
// Constants live in bcache_maint_params.svh.
package bcache_maint_pkg;
  `include "bcache_maint_params.svh"

  // Decoded cache operating state
  typedef enum logic [1:0] {
    CACHE_OFF       = 2'b00,
    CACHE_FORCE_HIT = 2'b01,
    CACHE_ETM       = 2'b10,
    CACHE_ON        = 2'b11
  } cache_state_e;

  // One tag store entry
  typedef struct packed {
    logic [`TS_TAG_HI-`TS_TAG_LO:0] tag;
    logic [`TS_ECC_HI-`TS_ECC_LO:0] ecc;
    logic                           owned;
    logic                           valid;
  } tag_entry_s;

  // Control register bits that steer this block
  typedef struct packed {
    logic enable;
    logic force_hit;
    logic software_error_transition;
    logic hardware_error_transition;
    logic supplied_check_bits;
    logic disable_errors;
  } cache_ctl_s;

  // Register access request from the core
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  // Request routing produced for the memory side
  typedef struct packed {
    logic dma_to_pcache_inval;
    logic miss_to_bus;
    logic fill_to_pcache;
    logic use_bcache;
    logic force_hit;
    logic interlock_ownership_read_hexa;
    logic write_quad;
    logic read_hexa;
    logic modify_as_dread;
    logic errors_enabled;
  } route_s;

  // Deallocate sequencer states
  typedef enum logic [2:0] {
    DS_IDLE     = 3'b000,
    DS_WAIT     = 3'b001,
    DS_LOOKUP   = 3'b010,
    DS_WB       = 3'b011,
    DS_UPDATE   = 3'b100
  } dealloc_state_e;
endpackage

// file: hw/bcache_maint.sv
// Backup-cache tag store access, block deallocate and cache mode decode.
// Assumes the core holds a register request until o_req_done, and the
// write-back engine and pending-fill table are outside this block.
// Write-back data movement and error logging live outside as well.
`timescale 1ns/1ps

`include "bcache_maint_params.svh"

// Function
// - Tag store register reads and writes work in every cache state.
// - Stall tag store access while a matching pending-fill entry is valid.
// - Select on address 24:22 = 100; index 16:5, tag 28:17.
// - Word holds valid 9, owned 10, check bits 16:11, tag 28:17.
// - Store supplied check bits only if enabled; else compute them.
// - Reads return stored check bits; no checking, no errors.
// - Deallocate register is write-only; index in address bits 16:5.
// - Hold deallocate while a matching pending-fill entry is valid.
// - Deallocate: invalid none; valid invalidate; owned write back first.
// - Deallocates run in all states; real lookup in forced-hit mode.
// - After deallocate clear valid/owned, store correct check bits.
// - Deallocate never writes data RAMs; errors still reported.
// - State priority: off, forced-hit, error-transition, on.
// - Off: no cache accesses, no error detection, state unchanged.
// - Off: DMA to primary invalidates; misses, writes, fills bypass.
// - Off: interlocked pairs become hexaword ownership read, quadword write.
// - No cache: writes quadword, reads hexaword.
// - Off: modify-intent reads use plain data read.
// - Forced-hit: all reads and writes hit as owned-valid, tags unchanged.
// - Forced-hit: DMA goes to primary invalidates, no lookup.
// - Forced-hit: no victim deallocations or write-backs.
// - Forced-hit: errors detected unless inhibit bit set.
module bcache_maint (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rstn,
  input  wire bcache_maint_pkg::reg_req_s   i_req,
  input  wire bcache_maint_pkg::cache_ctl_s i_ctl,
  input  wire logic                         i_fill_match,
  input  wire logic                         i_wb_done,
  output logic                              o_req_done,
  output logic [31:0]                       o_rdata,
  output logic [11:0]                       o_fill_idx,
  output logic                              o_fill_chk,
  output logic                              o_wb_req,
  output logic [11:0]                       o_wb_idx,
  output logic [11:0]                       o_wb_tag,
  output logic                              o_pcache_inval,
  output logic [11:0]                       o_pcache_idx,
  output bcache_maint_pkg::cache_state_e    o_state,
  output bcache_maint_pkg::route_s          o_route
);
  import bcache_maint_pkg::*;

  // Tag store array, one entry per block
  // Left unreset: software writes every entry with valid and owned
  // clear before it enables the cache
  tag_entry_s tag_ram [`TS_DEPTH];

  // Check bits over tag, owned and valid; simple parity groups
  // Not a full correcting code; it only has to agree between the
  // register write path and the deallocate path, which share it.
  // Kept as a function so both callers stay identical
  function automatic logic [`TS_ECC_HI-`TS_ECC_LO:0] calc_ecc(
    input logic [`TS_TAG_HI-`TS_TAG_LO:0] tag,
    input logic                           owned,
    input logic                           valid);
    logic [13:0] v;
    logic [5:0]  e;
    v = {tag, owned, valid};
    e[0] = ^(v & 14'h1555);
    e[1] = ^(v & 14'h2666);
    e[2] = ^(v & 14'h0787);
    e[3] = ^(v & 14'h07f8);
    e[4] = ^(v & 14'h3800);
    e[5] = ^v;
    return e;
  endfunction

  // Selector field of a register address
  function automatic logic [2:0] addr_sel(input logic [31:0] a);
    return a[`TS_SEL_HI:`TS_SEL_LO];
  endfunction

  // Index field of a register address
  function automatic logic [`TS_IDX_W-1:0] addr_idx(input logic [31:0] a);
    return a[`TS_IDX_HI:`TS_IDX_LO];
  endfunction

  // Decode results, shared by the sequencer and the fill lookup
  logic tag_hit;
  logic dealloc_hit;
  logic [`TS_IDX_W-1:0] req_idx;

  // Address decode; deallocate also demands its fixed zero fields
  // Bit 21 of a deallocate address is ignored; reads there never finish
  always_comb begin
    req_idx = addr_idx(i_req.addr);
    tag_hit = 1'b0;
    dealloc_hit = 1'b0;
    if (addr_sel(i_req.addr) == `TS_SEL_TAGSTORE) begin
      tag_hit = i_req.rd | i_req.wr;
    end else if (addr_sel(i_req.addr) == `TS_SEL_DEALLOC &&
                 i_req.addr[`DEALLOC_RSVD_HI:`DEALLOC_RSVD_LO] == 7'h00 &&
                 i_req.addr[`DEALLOC_Z_HI:`DEALLOC_Z_LO] == 4'h0 &&
                 i_req.addr[`DEALLOC_LOW_HI:0] == 5'h00) begin
      dealloc_hit = i_req.wr;
    end
  end

  // State decode with fixed priority
  // Off wins over every other bit, so a stale forced-hit never leaks
  always_comb begin
    if (!i_ctl.enable) begin
      o_state = CACHE_OFF;
    end else if (i_ctl.force_hit) begin
      o_state = CACHE_FORCE_HIT;
    end else if (i_ctl.software_error_transition || i_ctl.hardware_error_transition) begin
      o_state = CACHE_ETM;
    end else begin
      o_state = CACHE_ON;
    end
  end

  // Request routing toward primary cache and system bus
  // Error-transition routing stays with the main cache pipeline;
  // only the off and forced-hit bypass flags come from here.
  // Error detection follows disable_errors in every enabled state
  always_comb begin
    o_route = '0;
    o_route.use_bcache = (o_state == CACHE_ON) || (o_state == CACHE_ETM);
    o_route.errors_enabled = (o_state != CACHE_OFF) && !i_ctl.disable_errors;
    if (o_state == CACHE_OFF) begin
      o_route.dma_to_pcache_inval = 1'b1;
      o_route.miss_to_bus = 1'b1;
      o_route.fill_to_pcache = 1'b1;
      o_route.interlock_ownership_read_hexa = 1'b1;
      o_route.write_quad = 1'b1;
      o_route.read_hexa = 1'b1;
      o_route.modify_as_dread = 1'b1;
    end else if (o_state == CACHE_FORCE_HIT) begin
      o_route.force_hit = 1'b1;
      o_route.dma_to_pcache_inval = 1'b1;
    end
  end


  // Sequencer state, block index and the entry seen at lookup
  dealloc_state_e ds;
  dealloc_state_e next_ds;
  logic [`TS_IDX_W-1:0] d_idx;
  logic [`TS_IDX_W-1:0] next_d_idx;
  tag_entry_s d_ent;
  tag_entry_s next_d_ent;

  // Registered outputs and their next values
  logic        req_done;
  logic        next_req_done;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        wb_req;
  logic        next_wb_req;
  logic        inval;
  logic        next_inval;

  // Tag RAM write port and the entry read at the held index
  logic        ram_we;
  tag_entry_s  ram_wd;
  logic [`TS_IDX_W-1:0] ram_wa;
  tag_entry_s  rd_ent;

  // Read at the registered index, which keeps the address path short
  assign rd_ent = tag_ram[d_idx];

  // Sequencer: one operation at a time; no path touches the data RAMs
  always_comb begin
    next_ds = ds;
    next_d_idx = d_idx;
    next_d_ent = d_ent;
    next_req_done = 1'b0;
    next_rdata = rdata;
    next_wb_req = 1'b0;
    next_inval = 1'b0;
    ram_we = 1'b0;
    ram_wa = d_idx;
    ram_wd = '0;
    case (ds)
      DS_IDLE: begin
        // A done pulse blocks retaking a request not yet dropped
        if ((tag_hit || dealloc_hit) && !req_done) begin
          next_d_idx = req_idx;
          next_ds = DS_WAIT;
        end
      end
      DS_WAIT: begin
        // Hold while the pending-fill table matches this block
        // The index is checked again every cycle until the table clears
        if (!i_fill_match) begin
          if (tag_hit) begin
            if (i_req.wr) begin
              ram_we = 1'b1;
              ram_wd.valid = i_req.wdata[`TS_VALID_BIT];
              ram_wd.owned = i_req.wdata[`TS_OWNED_BIT];
              ram_wd.tag = i_req.wdata[`TS_TAG_HI:`TS_TAG_LO];
              ram_wd.ecc = i_ctl.supplied_check_bits ?
                           i_req.wdata[`TS_ECC_HI:`TS_ECC_LO] :
                           calc_ecc(ram_wd.tag, ram_wd.owned, ram_wd.valid);
            end else begin
              next_rdata = `ZERO_WORD;
              next_rdata[`TS_VALID_BIT] = rd_ent.valid;
              next_rdata[`TS_OWNED_BIT] = rd_ent.owned;
              next_rdata[`TS_ECC_HI:`TS_ECC_LO] = rd_ent.ecc;
              next_rdata[`TS_TAG_HI:`TS_TAG_LO] = rd_ent.tag;
            end
            next_req_done = 1'b1;
            next_ds = DS_IDLE;
          end else begin
            next_ds = DS_LOOKUP;
          end
        end
      end
      DS_LOOKUP: begin
        // Real lookup even in forced-hit mode
        next_d_ent = rd_ent;
        if (!rd_ent.valid) begin
          next_req_done = 1'b1;
          next_ds = DS_IDLE;
        end else if (rd_ent.owned) begin
          next_inval = 1'b1;
          next_wb_req = 1'b1;
          next_ds = DS_WB;
        end else begin
          next_inval = 1'b1;
          next_ds = DS_UPDATE;
        end
      end
      DS_WB: begin
        // Write-back engine reports its own data errors
        // Request drops in the cycle after the done pulse
        next_wb_req = !i_wb_done;
        if (i_wb_done) begin
          next_ds = DS_UPDATE;
        end
      end
      DS_UPDATE: begin
        // Stored tag kept; only valid, owned and check bits change
        ram_we = 1'b1;
        ram_wd.valid = 1'b0;
        ram_wd.owned = 1'b0;
        ram_wd.tag = d_ent.tag;
        ram_wd.ecc = calc_ecc(d_ent.tag, 1'b0, 1'b0);
        next_req_done = 1'b1;
        next_ds = DS_IDLE;
      end
      default: begin
        next_ds = DS_IDLE;
      end
    endcase
  end

  // Sequencer registers
  // Reset branch loads constants only
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ds <= DS_IDLE;
      d_idx <= `ZERO_IDX;
      d_ent <= '0;
      req_done <= 1'b0;
      rdata <= `ZERO_WORD;
      wb_req <= 1'b0;
      inval <= 1'b0;
    end else begin
      ds <= next_ds;
      d_idx <= next_d_idx;
      d_ent <= next_d_ent;
      req_done <= next_req_done;
      rdata <= next_rdata;
      wb_req <= next_wb_req;
      inval <= next_inval;
    end
  end

  // Tag RAM write port; no reset, contents are garbage at power-up
  // One port serves register writes and deallocates; never both at once
  always_ff @(posedge i_core_clk) begin
    if (ram_we) begin
      tag_ram[ram_wa] <= ram_wd;
    end
  end

  // Completion and read data straight from flip-flops
  assign o_req_done = req_done;
  assign o_rdata = rdata;

  // Fill lookup index: live address while idle, held index afterwards
  assign o_fill_idx = (ds == DS_IDLE) ? req_idx : d_idx;
  assign o_fill_chk = (ds == DS_WAIT);

  // Write-back and primary-cache invalidate toward the far side
  assign o_wb_req = wb_req;
  assign o_wb_idx = d_idx;
  assign o_wb_tag = d_ent.tag;
  assign o_pcache_inval = inval;
  assign o_pcache_idx = d_idx;
endmodule // bcache_maint

// file: dv/bcache_maint_assertions.sv
// Checker for bcache_maint, bound to its top-level ports.
// Assumes one clock domain and the types of bcache_maint_pkg.
`timescale 1ns/1ps
module bcache_maint_assertions
  import bcache_maint_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_rstn,
  input wire cache_ctl_s   i_ctl,
  input wire logic         i_fill_match,
  input wire logic         i_wb_done,
  input wire logic         o_req_done,
  input wire logic [31:0]  o_rdata,
  input wire logic         o_fill_chk,
  input wire logic         o_wb_req,
  input wire cache_state_e o_state,
  input wire route_s       o_route
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  // Mode decode follows the enable, forced-hit priority
  a_off_decode: assert property (!i_ctl.enable |-> o_state == CACHE_OFF)
    else $error("off decode wrong");
  a_fh_decode: assert property (i_ctl.enable && i_ctl.force_hit |-> o_state == CACHE_FORCE_HIT)
    else $error("forced-hit decode wrong");
  // Off routing bypasses the cache and its error checks
  a_off_quiet: assert property (o_state == CACHE_OFF |-> !o_route.errors_enabled && !o_route.use_bcache)
    else $error("cache used while off");
  a_off_route: assert property (o_state == CACHE_OFF |-> o_route.miss_to_bus && o_route.fill_to_pcache
    && o_route.dma_to_pcache_inval)
    else $error("off routing wrong");
  a_off_sizes: assert property (o_state == CACHE_OFF |-> o_route.interlock_ownership_read_hexa && o_route.write_quad
    && o_route.read_hexa && o_route.modify_as_dread)
    else $error("off lengths wrong");
  a_fh_route: assert property (o_state == CACHE_FORCE_HIT |-> o_route.force_hit && o_route.dma_to_pcache_inval)
    else $error("forced-hit routing wrong");
  a_fh_errors: assert property (o_state == CACHE_FORCE_HIT |-> o_route.errors_enabled == !i_ctl.disable_errors)
    else $error("forced-hit error enable wrong");
  // A pending fill on the block holds the request back
  a_fill_stall: assert property (o_fill_chk && i_fill_match |=> !o_req_done)
    else $error("done despite pending fill");
  a_wb_hold: assert property (o_wb_req && !i_wb_done |=> o_wb_req)
    else $error("write-back dropped early");
  a_read_zero: assert property (o_req_done |-> o_rdata[8:0] == 9'h000 && o_rdata[31:29] == 3'h0)
    else $error("read bits outside fields");
endmodule // bcache_maint_assertions

bind bcache_maint bcache_maint_assertions chk (.i_core_clk, .i_rstn, .i_ctl, .i_fill_match,
  .i_wb_done, .o_req_done, .o_rdata, .o_fill_chk, .o_wb_req, .o_state, .o_route);

// file: dv/bcache_far_model.sv
// Far side: pending-fill table lookup and write-back engine.
// Assumes the bench names the block whose fills are in flight.
`timescale 1ns/1ps
module bcache_far_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic [11:0] i_fill_idx,
  input  wire logic        i_busy,
  input  wire logic [11:0] i_busy_idx,
  input  wire logic        i_wb_req,
  input  wire logic [3:0]  i_wb_lat,
  output logic             o_fill_match,
  output logic             o_wb_done
);
  logic [7:0] cnt;
  // Table answers at once for the index under check
  assign o_fill_match = i_busy && (i_fill_idx == i_busy_idx);
  // One done pulse per write-back; a larger i_wb_lat models a slow bus
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt       <= 8'h00;
      o_wb_done <= 1'b0;
    end else begin
      cnt       <= i_wb_req ? cnt + 8'h01 : 8'h00;
      o_wb_done <= i_wb_req && (cnt == {4'h0, i_wb_lat});
    end
  end
endmodule // bcache_far_model

// file: dv/tb.sv
// Self-checking bench for bcache_maint with the far-side model.
// Assumes a 100 MHz clock and requests held until o_req_done.
`timescale 1ns/1ps
module tb;
  import bcache_maint_pkg::*;
  typedef struct packed {
    logic [5:0]   c;
    logic [11:0]  i;
    logic [31:0]  d;
    cache_state_e s;
    logic         e;
  } row_s;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  reg_req_s     req = '0;
  cache_ctl_s   ctl = '0;
  logic         busy = 1'b0;
  logic [11:0]  bidx = 12'h000;
  logic [3:0]   wlat = 4'h9;
  logic         fm, wbd, done, fchk, wbr, inv;
  logic [31:0]  rdata, rd_v, w0;
  logic [11:0]  fidx, widx, wtag, pidx, wi, wt, pl, ix;
  cache_state_e st;
  route_s       rt;
  int           mismatches = 0;
  int           checks_done = 0;
  int           lat, ninv, nwb;
  row_s         rows [6] = '{
    '{6'h02, 12'h000, 32'hFFFF_FFFF, CACHE_OFF, 1'b0},
    '{6'h32, 12'hFFF, 32'h1234_5678, CACHE_FORCE_HIT, 1'b1},
    '{6'h33, 12'h800, 32'h0BCD_EF00, CACHE_FORCE_HIT, 1'b0},
    '{6'h2A, 12'h5A5, 32'hA5A5_A5A5, CACHE_ETM, 1'b1},
    '{6'h26, 12'h3C3, 32'h0F0F_F0F0, CACHE_ETM, 1'b1},
    '{6'h22, 12'h001, 32'h1555_5600, CACHE_ON, 1'b1}};

  always #5 clk = ~clk;

  bcache_maint uut (.i_core_clk(clk), .i_rstn(rstn), .i_req(req), .i_ctl(ctl),
    .i_fill_match(fm), .i_wb_done(wbd), .o_req_done(done), .o_rdata(rdata), .o_fill_idx(fidx),
    .o_fill_chk(fchk), .o_wb_req(wbr), .o_wb_idx(widx), .o_wb_tag(wtag), .o_pcache_inval(inv),
    .o_pcache_idx(pidx), .o_state(st), .o_route(rt));
  bcache_far_model far (.i_core_clk(clk), .i_rstn(rstn), .i_fill_idx(fidx), .i_busy(busy),
    .i_busy_idx(bidx), .i_wb_req(wbr), .i_wb_lat(wlat), .o_fill_match(fm), .o_wb_done(wbd));

  // Count invalidates and write-backs, keeping the last block of each
  always @(posedge clk) begin
    if (inv) begin
      ninv++;
      pl = pidx;
    end
    if (wbr) begin
      wi = widx;
      wt = wtag;
    end
    if (wbd) nwb++;
  end

  function automatic logic [31:0] ta(input logic [11:0] i);
    return {7'h00, 3'h4, 5'h00, i, 5'h00};
  endfunction
  function automatic logic [31:0] da(input logic [11:0] i);
    return {7'h00, 3'h5, 5'h00, i, 5'h00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hold the request until done; lat stays 0 if it is never answered
  task automatic acc(input logic r, input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 req = '{r, w, a, d};
    lat = 0;
    for (int n = 1; n <= 40 && lat == 0; n++) begin
      @(posedge clk);
      #1 if (done) lat = n;
    end
    rd_v = rdata;
    req = '0;
  endtask

  // Fills pending on the target block for twelve cycles
  task automatic stall(input logic r, input logic [31:0] a);
    busy = 1'b1;
    bidx = a[16:5];
    fork
      acc(r, !r, a, 32'h0000_0000);
      begin
        repeat (12) @(posedge clk);
        #1 busy = 1'b0;
      end
    join
    chk(lat > 10, 1'b1);
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Watchdog sized well past the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    #1 chk({done, wbr, inv}, 3'h0);
    rstn = 1'b1;
    // Tag store write and read back in every cache state
    foreach (rows[k]) begin
      ctl = rows[k].c;
      #1 chk(st, rows[k].s);
      chk(rt.errors_enabled, rows[k].e);
      acc(1'b0, 1'b1, ta(rows[k].i), rows[k].d);
      acc(1'b1, 1'b0, ta(rows[k].i), 32'h0000_0000);
      chk(rd_v, rows[k].d & 32'h1FFF_FE00);
      chk(lat, 2);
    end
    acc(1'b1, 1'b0, ta(rows[0].i), 32'h0000_0000);
    chk(rd_v, 32'h1FFF_FE00);
    stall(1'b1, ta(rows[1].i));
    // Deallocates in forced-hit: invalid, valid, owned
    ctl = 6'h30;
    for (int k = 0; k < 3; k++) begin
      ix = 12'h100 + 12'(k);
      acc(1'b0, 1'b1, ta(ix), {3'h0, 12'h5A0 + ix, 6'h00, k == 2, k > 0, 9'h000});
      ninv = 0;
      nwb = 0;
      acc(1'b0, 1'b1, da(ix) | (k == 1 ? 32'h0020_0000 : 32'h0000_0000), 32'h0000_0000);
      if (k < 2) chk(lat, 3 + k);
      chk(ninv, k > 0);
      chk(nwb, k == 2);
      if (k > 0) chk(pl, ix);
      if (k == 2) chk({wi, wt}, {ix, 12'h5A0 + ix});
      acc(1'b1, 1'b0, ta(ix), 32'h0000_0000);
      w0 = rd_v;
      chk(w0[10:9], 2'h0);
      acc(1'b0, 1'b1, ta(12'h200), {w0[31:17], 17'h0_0000});
      acc(1'b1, 1'b0, ta(12'h200), 32'h0000_0000);
      chk(rd_v, w0);
    end
    stall(1'b0, da(12'h102));
    // Reads of the deallocate register and nonzero low bits are ignored
    acc(1'b1, 1'b0, da(12'h100), 32'h0000_0000);
    chk(lat, 0);
    acc(1'b0, 1'b1, da(12'h100) | 32'h0000_0010, 32'h0000_0000);
    chk(lat, 0);
    stop_test();
  end
endmodule // tb
